// File: core/cpns_pkg.sv
// package of constants for the serial port and nonvolatile store controller
//
// Overview of operation
// - port starts msb first; bits 1 and 6 of register zero select lsb
// - msb first: bits shifted msb first, address decrements per data byte
// - lsb first: bits shifted lsb first, address increments per byte
// - multibyte access steps every consecutive address, none skipped
// - after crossing top or zero, writes blocked and reads return zero
// - streaming always ends when it crosses an address boundary
// - instruction: r/w bit 15, length bits 14:13, zero bit 12, address
// - during nvm transfer registers unavailable except busy flag at 0xb00
// - busy flag set when a store transfer starts, cleared at its end
// - i2c slave address answered with nack while transfer runs
// - bit 4 of 0x232 routes busy flag to first status output
// - store holds 512 bytes; save takes 46 ms, load 40 ms
// - hard reset loads from store if boot select high, else defaults
// - hard reset also runs an output synchronisation
// - outputs start 2 us after reset with defaults, 40 ms after a load
// - no direct serial path writes the store; only the save sequence
// - save copies registers to store, then clears save start itself
// - host clears write enable after busy falls; store writes refused
// - failed transfer sets error bit 0 of 0xb01, good one leaves zero
// - self clearing update bit copies shadow changes to active bank
// - with boot select low, soft restore bit starts a store load
package cpns_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_ZERO = 12'h000;
  localparam logic [11:0] ADDR_TOP = 12'h234;
  localparam logic [11:0] ADDR_PINCFG = 12'h232;
  localparam logic [11:0] ADDR_UPDATE = 12'h234;
  localparam logic [11:0] ADDR_STATUS = 12'hb00;
  localparam logic [11:0] ADDR_ERROR = 12'hb01;
  localparam logic [11:0] ADDR_NVCTL = 12'hb02;
  localparam logic [11:0] ADDR_SAVE = 12'hb03;
  localparam int INSTR_RNW = 15;
  localparam int INSTR_LEN_HI = 14;
  localparam int INSTR_LEN_LO = 13;
  localparam int INSTR_TOP_BIT = 12;
  localparam logic [1:0] LEN_STREAM = 2'h3;
  localparam int LSB_BIT_A = 1;
  localparam int LSB_BIT_B = 6;
  localparam int PINCFG_BUSY_BIT = 4;
  localparam int UPDATE_BIT = 0;
  localparam int NVWE_BIT = 0;
  localparam int SOFT_LOAD_BIT = 1;
  localparam int SAVE_BIT = 0;
  localparam int NVM_BYTES = 512;
  localparam logic LSB_FIRST_RST = 1'b0;
  localparam longint CLK_HZ = 20000000;
  localparam longint SAVE_TIME_MS = 46;
  localparam longint LOAD_TIME_MS = 40;
  localparam longint START_TIME_NS = 2000;
  localparam int SAVE_CYC = int'(SAVE_TIME_MS * CLK_HZ / 1000);
  localparam int LOAD_CYC = int'(LOAD_TIME_MS * CLK_HZ / 1000);
  localparam int START_CYC = int'(START_TIME_NS * CLK_HZ / 1000000000);
  localparam int BOOT_WAIT = 3;
  typedef enum logic [2:0] {
    CPNS_BOOT = 3'h0,
    CPNS_DFLT = 3'h1,
    CPNS_LOAD = 3'h3,
    CPNS_IDLE = 3'h2,
    CPNS_SAVE = 3'h6
  } cpns_state_t;
endpackage

// File: core/cpns_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none
module cpns_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// File: core/cpns_nvm_ctrl.sv
// store and restore sequencer with transfer timing
`timescale 1ns/100ps
`default_nettype none
module cpns_nvm_ctrl #(
  parameter int SAVE_CYCLES = cpns_pkg::SAVE_CYC,
  parameter int LOAD_CYCLES = cpns_pkg::LOAD_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic boot_sel,
  input wire logic nvm_fail,
  input wire logic save_req,
  input wire logic load_req,
  output logic busy,
  output logic error,
  output logic saving,
  output logic restore_nvm,
  output logic restore_default,
  output logic out_sync,
  output logic outputs_run
);
  localparam int LONGEST = SAVE_CYCLES > LOAD_CYCLES ?
                           SAVE_CYCLES : LOAD_CYCLES;
  localparam int CW = $clog2(LONGEST > cpns_pkg::START_CYC ?
                             LONGEST + 1 : cpns_pkg::START_CYC + 1);
  cpns_pkg::cpns_state_t state;
  cpns_pkg::cpns_state_t next_state;
  logic [CW-1:0] cnt;
  logic fail_seen;
  logic first_load;
  wire cnt_done = (cnt == '0);
  wire save_go = (state == cpns_pkg::CPNS_IDLE) && save_req;
  wire load_go = (state == cpns_pkg::CPNS_IDLE) && load_req && !boot_sel;

  initial begin
    if (SAVE_CYCLES < 1 || LOAD_CYCLES < 1)
      $error("cpns_nvm_ctrl: cycle counts must be at least one");
  end

  always_comb begin
    next_state = state;
    unique case (state)
      cpns_pkg::CPNS_BOOT:
        if (cnt_done) begin
          next_state = boot_sel ? cpns_pkg::CPNS_LOAD : cpns_pkg::CPNS_DFLT;
        end
      cpns_pkg::CPNS_DFLT:
        if (cnt_done) next_state = cpns_pkg::CPNS_IDLE;
      cpns_pkg::CPNS_LOAD:
        if (cnt_done) next_state = cpns_pkg::CPNS_IDLE;
      cpns_pkg::CPNS_IDLE:
        if (save_go) next_state = cpns_pkg::CPNS_SAVE;
        else if (load_go) next_state = cpns_pkg::CPNS_LOAD;
      cpns_pkg::CPNS_SAVE:
        if (cnt_done) next_state = cpns_pkg::CPNS_IDLE;
      default: next_state = cpns_pkg::CPNS_BOOT;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= cpns_pkg::CPNS_BOOT;
      cnt <= CW'(cpns_pkg::BOOT_WAIT);
      busy <= 1'b0;
      error <= 1'b0;
      saving <= 1'b0;
      fail_seen <= 1'b0;
      first_load <= 1'b1;
      restore_nvm <= 1'b0;
      restore_default <= 1'b0;
      out_sync <= 1'b0;
      outputs_run <= 1'b0;
    end else begin
      state <= next_state;
      restore_nvm <= 1'b0;
      restore_default <= 1'b0;
      out_sync <= 1'b0;
      if (next_state != state) begin
        unique case (next_state)
          cpns_pkg::CPNS_DFLT: cnt <= CW'(cpns_pkg::START_CYC - 1);
          cpns_pkg::CPNS_LOAD: cnt <= CW'(LOAD_CYCLES - 1);
          cpns_pkg::CPNS_SAVE: cnt <= CW'(SAVE_CYCLES - 1);
          default: cnt <= '0;
        endcase
      end else if (!cnt_done) begin
        cnt <= cnt - 1'b1;
      end
      if (state == cpns_pkg::CPNS_BOOT && cnt_done && !boot_sel)
        restore_default <= 1'b1;
      if (next_state == cpns_pkg::CPNS_LOAD ||
          next_state == cpns_pkg::CPNS_SAVE) begin
        busy <= 1'b1;
        saving <= (next_state == cpns_pkg::CPNS_SAVE);
        if (state != next_state) fail_seen <= 1'b0;
        else if (nvm_fail) fail_seen <= 1'b1;
      end else begin
        busy <= 1'b0;
        saving <= 1'b0;
      end
      if ((state == cpns_pkg::CPNS_LOAD || state == cpns_pkg::CPNS_SAVE) &&
          next_state == cpns_pkg::CPNS_IDLE)
        error <= fail_seen | nvm_fail;
      if (state == cpns_pkg::CPNS_LOAD && next_state == cpns_pkg::CPNS_IDLE)
        restore_nvm <= 1'b1;
      if ((state == cpns_pkg::CPNS_LOAD || state == cpns_pkg::CPNS_DFLT) &&
          next_state == cpns_pkg::CPNS_IDLE && first_load) begin
        out_sync <= 1'b1;
        outputs_run <= 1'b1;
        first_load <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: core/cpns_port.sv
// serial control port sequencer with nonvolatile store control
`timescale 1ns/100ps
`default_nettype none
module cpns_port #(
  parameter int SAVE_CYCLES = cpns_pkg::SAVE_CYC,
  parameter int LOAD_CYCLES = cpns_pkg::LOAD_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  input wire logic [7:0] reg_rdata,
  output logic [11:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_we,
  input wire logic boot_sel,
  input wire logic nvm_fail,
  input wire logic status_alt,
  output logic first_status_output,
  output logic i2c_addr_nack,
  output logic shadow_update,
  output logic restore_nvm,
  output logic restore_default,
  output logic out_sync,
  output logic outputs_run,
  output logic nvm_writing
);
  //////////////////////////////////////////////////////////////////////////
  // elaboration checks
  initial begin
    if (SAVE_CYCLES < 1 || LOAD_CYCLES < 1)
      $error("cpns_port: cycle counts must be at least one");
  end

  //////////////////////////////////////////////////////////////////////////
  // link domain: frame state, cleared while chip select is high
  wire lk_rst_n = nrst & ~cs_n;
  logic lsb_first;
  logic in_data;
  logic [3:0] icnt;
  logic [2:0] bcnt;
  logic [15:0] instr;
  logic [7:0] wbyte;
  logic rnw;
  logic [1:0] len;
  logic [1:0] nbytes;
  logic [11:0] addr;
  logic past_end;
  logic ended;
  logic ctl_tog;
  logic [1:0] ctl_sel;
  logic [7:0] ctl_data;
  logic [3:0] lk_stat;

  wire lk_busy = lk_stat[0];
  wire lk_err = lk_stat[1];
  wire lk_nvwe = lk_stat[2];
  wire lk_save = lk_stat[3];

  // bit order of the shift paths
  wire [15:0] next_instr = lsb_first ? {sdio_in, instr[15:1]}
                                     : {instr[14:0], sdio_in};
  wire [7:0] next_wbyte = lsb_first ? {sdio_in, wbyte[7:1]}
                                    : {wbyte[6:0], sdio_in};
  wire instr_last = !in_data && (icnt == 4'hf);
  wire byte_last = in_data && (bcnt == 3'h7) && !ended;
  wire crossing = lsb_first ? (addr == cpns_pkg::ADDR_TOP)
                            : (addr == cpns_pkg::ADDR_ZERO);
  wire [11:0] next_addr = lsb_first ? addr + 12'h001
                                    : addr - 12'h001;
  wire last_count = (len != cpns_pkg::LEN_STREAM) && (nbytes == len);
  wire wr_fire = byte_last && !rnw && !past_end && !lk_busy;

  // local control registers reached through the port
  function automatic logic is_ctl(input logic [11:0] a);
    is_ctl = (a == cpns_pkg::ADDR_PINCFG) || (a == cpns_pkg::ADDR_UPDATE) ||
             (a == cpns_pkg::ADDR_NVCTL) || (a == cpns_pkg::ADDR_SAVE);
  endfunction

  function automatic logic [1:0] ctl_code(input logic [11:0] a);
    if (a == cpns_pkg::ADDR_PINCFG) ctl_code = 2'h0;
    else if (a == cpns_pkg::ADDR_UPDATE) ctl_code = 2'h1;
    else if (a == cpns_pkg::ADDR_NVCTL) ctl_code = 2'h2;
    else ctl_code = 2'h3;
  endfunction

  // read value of the current address
  wire stat_addr = (addr == cpns_pkg::ADDR_STATUS);
  wire [7:0] stat_byte = {7'h00, lk_busy};
  wire [7:0] err_byte = {7'h00, lk_err};
  wire [7:0] nvctl_byte = {7'h00, lk_nvwe};
  wire [7:0] save_byte = {7'h00, lk_save};
  wire [7:0] local_byte = (addr == cpns_pkg::ADDR_ERROR) ? err_byte :
                          (addr == cpns_pkg::ADDR_NVCTL) ? nvctl_byte :
                          (addr == cpns_pkg::ADDR_SAVE) ? save_byte :
                          reg_rdata;
  wire [7:0] rd_byte = past_end ? 8'h00 :
                       stat_addr ? stat_byte :
                       lk_busy ? 8'h00 :
                       local_byte;
  wire [2:0] rd_idx = lsb_first ? bcnt : 3'h7 - bcnt;

  //////////////////////////////////////////////////////////////////////////
  // link domain: bit order survives frames, reset only by hard reset
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      lsb_first <= cpns_pkg::LSB_FIRST_RST;
    end else if (wr_fire && addr == cpns_pkg::ADDR_ZERO) begin
      lsb_first <= next_wbyte[cpns_pkg::LSB_BIT_A] &
                   next_wbyte[cpns_pkg::LSB_BIT_B];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // link domain: instruction and data sequencing
  always_ff @(posedge sclk or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      in_data <= 1'b0;
      icnt <= 4'h0;
      bcnt <= 3'h0;
      instr <= 16'h0000;
      wbyte <= 8'h00;
      rnw <= 1'b0;
      len <= 2'h0;
      nbytes <= 2'h0;
      addr <= 12'h000;
      past_end <= 1'b0;
      ended <= 1'b0;
    end else if (!in_data) begin
      instr <= next_instr;
      icnt <= icnt + 4'h1;
      if (instr_last) begin
        in_data <= 1'b1;
        rnw <= next_instr[cpns_pkg::INSTR_RNW];
        len <= next_instr[cpns_pkg::INSTR_LEN_HI:cpns_pkg::INSTR_LEN_LO];
        addr <= next_instr[11:0];
        past_end <= next_instr[cpns_pkg::INSTR_TOP_BIT];
      end
    end else if (!ended) begin
      wbyte <= next_wbyte;
      bcnt <= bcnt + 3'h1;
      if (byte_last) begin
        addr <= next_addr;
        nbytes <= nbytes + 2'h1;
        past_end <= past_end | crossing;
        ended <= last_count ||
                 (len == cpns_pkg::LEN_STREAM && crossing);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // link domain: register bank writes and control hand-off
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      reg_we <= 1'b0;
      reg_wdata <= 8'h00;
      ctl_tog <= 1'b0;
      ctl_sel <= 2'h0;
      ctl_data <= 8'h00;
    end else begin
      reg_we <= wr_fire && !is_ctl(addr);
      if (wr_fire) reg_wdata <= next_wbyte;
      if (wr_fire && is_ctl(addr)) begin
        ctl_tog <= ~ctl_tog;
        ctl_sel <= ctl_code(addr);
        ctl_data <= next_wbyte;
      end
    end
  end

  // bank address follows the sequencer, held between frames
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      reg_addr <= 12'h000;
    end else if (instr_last) begin
      reg_addr <= next_instr[11:0];
    end else if (wr_fire) begin
      reg_addr <= addr;
    end else if (byte_last) begin
      reg_addr <= next_addr;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // link domain: read data changes on the falling edge
  always_ff @(negedge sclk or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      sdio_out <= 1'b0;
      sdio_oe <= 1'b0;
    end else begin
      sdio_out <= rd_byte[rd_idx];
      sdio_oe <= in_data && rnw && (!ended || past_end);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // status into the link domain
  logic nv_busy;
  logic nv_err;
  logic nv_saving;
  logic nvm_we;

  cpns_sync #(
    .WIDTH(4)
  ) u_stat_sync (
    .clk(sclk),
    .rst_n(nrst),
    .d({nv_saving, nvm_we, nv_err, nv_busy}),
    .q(lk_stat)
  );

  //////////////////////////////////////////////////////////////////////////
  // system domain: pins and control event crossing
  logic [2:0] sys_in;
  logic ctl_tog_d;
  logic pin_busy_sel;
  logic save_req;
  logic load_req;

  cpns_sync #(
    .WIDTH(3)
  ) u_pin_sync (
    .clk(clk_sys),
    .rst_n(nrst),
    .d({ctl_tog, nvm_fail, boot_sel}),
    .q(sys_in)
  );

  wire boot_sel_s = sys_in[0];
  wire nvm_fail_s = sys_in[1];
  wire ctl_ev = sys_in[2] ^ ctl_tog_d;
  wire ev_pincfg = ctl_ev && ctl_sel == 2'h0;
  wire ev_update = ctl_ev && ctl_sel == 2'h1;
  wire ev_nvctl = ctl_ev && ctl_sel == 2'h2;
  wire ev_save = ctl_ev && ctl_sel == 2'h3;
  wire save_ask = ev_save && ctl_data[cpns_pkg::SAVE_BIT];
  wire load_ask = ev_nvctl && ctl_data[cpns_pkg::SOFT_LOAD_BIT];

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctl_tog_d <= 1'b0;
      pin_busy_sel <= 1'b0;
      nvm_we <= 1'b0;
      save_req <= 1'b0;
      load_req <= 1'b0;
      shadow_update <= 1'b0;
    end else begin
      ctl_tog_d <= sys_in[2];
      if (ev_pincfg)
        pin_busy_sel <= ctl_data[cpns_pkg::PINCFG_BUSY_BIT];
      if (ev_nvctl)
        nvm_we <= ctl_data[cpns_pkg::NVWE_BIT];
      save_req <= save_ask && nvm_we;
      load_req <= load_ask;
      shadow_update <= ev_update && ctl_data[cpns_pkg::UPDATE_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // system domain: store sequencer
  logic nv_restore_nvm;
  logic nv_restore_default;
  logic nv_sync;
  logic nv_run;

  cpns_nvm_ctrl #(
    .SAVE_CYCLES(SAVE_CYCLES),
    .LOAD_CYCLES(LOAD_CYCLES)
  ) u_nvm (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .boot_sel(boot_sel_s),
    .nvm_fail(nvm_fail_s),
    .save_req(save_req),
    .load_req(load_req),
    .busy(nv_busy),
    .error(nv_err),
    .saving(nv_saving),
    .restore_nvm(nv_restore_nvm),
    .restore_default(nv_restore_default),
    .out_sync(nv_sync),
    .outputs_run(nv_run)
  );

  //////////////////////////////////////////////////////////////////////////
  // system domain: registered outputs
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      first_status_output <= 1'b0;
      i2c_addr_nack <= 1'b0;
      restore_nvm <= 1'b0;
      restore_default <= 1'b0;
      out_sync <= 1'b0;
      outputs_run <= 1'b0;
      nvm_writing <= 1'b0;
    end else begin
      first_status_output <= pin_busy_sel ? nv_busy : status_alt;
      i2c_addr_nack <= nv_busy;
      restore_nvm <= nv_restore_nvm;
      restore_default <= nv_restore_default;
      out_sync <= nv_sync;
      outputs_run <= nv_run;
      nvm_writing <= nv_saving;
    end
  end
endmodule
`default_nettype wire

// File: verification/cpns_port_monitor.sv
// assertions on the pins of the serial port and store controller
`timescale 1ns/100ps
`default_nettype none
module cpns_port_monitor #(
  parameter int SAVE_CYCLES = 920000,
  parameter int LOAD_CYCLES = 800000
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic [11:0] reg_addr,
  input wire logic reg_we,
  input wire logic i2c_addr_nack,
  input wire logic shadow_update,
  input wire logic restore_nvm,
  input wire logic restore_default,
  input wire logic out_sync,
  input wire logic outputs_run,
  input wire logic nvm_writing
);
  int busy_len;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      busy_len <= 0;
    end else begin
      busy_len <= i2c_addr_nack ? busy_len + 1 : 0;
    end
  end
  sequence s_start;
    out_sync ##1 outputs_run;
  endsequence
  ////////////////////////////////////////////////////////////
  a_default_start:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      restore_default |-> ##[39:41] s_start) else $error("late start");
  a_busy_span:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      $fell(i2c_addr_nack) |-> busy_len inside
      {[LOAD_CYCLES - 2:SAVE_CYCLES + 2]}) else $error("busy length");
  a_load_end:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      restore_nvm |-> $past(i2c_addr_nack) || $past(i2c_addr_nack, 2))
      else $error("restore without load");
  a_run_cause:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      $rose(outputs_run) |-> out_sync || $past(out_sync))
      else $error("run without sync");
  a_run_holds:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      outputs_run |=> outputs_run) else $error("run dropped");
  a_save_busy:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      $rose(nvm_writing) |-> ##[0:2] i2c_addr_nack) else $error("no busy");
  a_save_clears:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      $fell(i2c_addr_nack) |-> ##[0:2] !nvm_writing)
      else $error("save flag stuck");
  a_update_pulse:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      shadow_update |=> !shadow_update) else $error("update not a pulse");
  a_we_pulse:
    assert property (@(posedge sclk) disable iff (!nrst)
      reg_we |=> !reg_we) else $error("write strobe too long");
  a_we_addr:
    assert property (@(posedge sclk) disable iff (!nrst)
      reg_we |-> reg_addr < 12'h234 && reg_addr != 12'h232)
      else $error("write to a blocked address");
endmodule
bind cpns_port cpns_port_monitor #(
  .SAVE_CYCLES(SAVE_CYCLES),
  .LOAD_CYCLES(LOAD_CYCLES)
) u_mon (
  .clk_sys(clk_sys), .nrst(nrst), .sclk(sclk), .reg_addr(reg_addr),
  .reg_we(reg_we), .i2c_addr_nack(i2c_addr_nack),
  .shadow_update(shadow_update), .restore_nvm(restore_nvm),
  .restore_default(restore_default), .out_sync(out_sync),
  .outputs_run(outputs_run), .nvm_writing(nvm_writing)
);
`default_nettype wire

// File: verification/cpns_spi_host.sv
// behavioural serial host driving frames into the control port
`timescale 1ns/100ps
`default_nettype none
module cpns_spi_host (
  output logic sclk,
  output logic cs_n,
  output logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe
);
  logic lsb;
  logic drv;
  assign sdio_in = sdio_oe ? sdio_out : drv;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    lsb = 1'b0;
    drv = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  task automatic tick();
    lsb = 1'b0;
    #24 sclk = 1'b1;
    #24 sclk = 1'b0;
  endtask
  task automatic frame(input logic [15:0] ins, input logic [31:0] wd,
      input int nb, output logic [31:0] rd);
    int k;
    int idx;
    rd = '0;
    cs_n = 1'b0;
    for (int i = 0; i <= 16 + 8 * nb; i++) begin
      k = i - 16;
      idx = 8 * (k / 8) + (lsb ? k % 8 : 7 - k % 8);
      if (i < 16) begin
        drv = lsb ? ins[i] : ins[15 - i];
      end else if (i < 16 + 8 * nb) begin
        drv = wd[idx];
      end else begin
        drv = ~drv;
      end
      #24 sclk = 1'b1;
      if (i >= 16 && i < 16 + 8 * nb) rd[idx] = sdio_in;
      #24 sclk = 1'b0;
    end
    #30 cs_n = 1'b1;
    #100;
  endtask
endmodule
`default_nettype wire

// File: verification/cpns_port_tb.sv
// self-checking bench for the serial port and store controller
`timescale 1ns/100ps
`default_nettype none
module cpns_port_tb;
  localparam int SAVE_N = 120;
  localparam int LOAD_N = 100;
  logic clk_sys, nrst, boot_sel, nvm_fail, status_alt, sclk, cs_n;
  logic sdio_in, sdio_out, sdio_oe, reg_we, first_status_output;
  logic i2c_addr_nack, shadow_update, restore_nvm, restore_default;
  logic out_sync, outputs_run, nvm_writing;
  logic [7:0] reg_rdata, reg_wdata;
  logic [11:0] reg_addr;
  logic [7:0] bank [0:4095];
  logic [11:0] wa [$];
  logic [7:0] wv [$];
  logic [31:0] q;
  int bad_count, cmp_count, upd;
  assign reg_rdata = bank[reg_addr];
  cpns_port #(.SAVE_CYCLES(SAVE_N), .LOAD_CYCLES(LOAD_N)) u_dut (
    .clk_sys(clk_sys), .nrst(nrst), .sclk(sclk), .cs_n(cs_n),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .boot_sel(boot_sel), .nvm_fail(nvm_fail),
    .status_alt(status_alt), .first_status_output(first_status_output),
    .i2c_addr_nack(i2c_addr_nack), .shadow_update(shadow_update),
    .restore_nvm(restore_nvm), .restore_default(restore_default),
    .out_sync(out_sync), .outputs_run(outputs_run),
    .nvm_writing(nvm_writing));
  cpns_spi_host u_host (.sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe));
  always @(negedge sclk) begin
    if (reg_we === 1'b1) begin
      wa.push_back(reg_addr);
      wv.push_back(reg_wdata);
      bank[reg_addr] = reg_wdata;
    end
  end
  always @(posedge clk_sys) if (shadow_update === 1'b1) upd++;
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input int n);
    logic [31:0] r;
    u_host.frame({1'b0, 2'(n - 1), 1'b0, a}, d, n, r);
  endtask
  task automatic rd(input logic [11:0] a, input int n, output logic [31:0] r);
    u_host.frame({1'b1, 2'(n - 1), 1'b0, a}, 32'ha5a5a5a5, n, r);
  endtask
  task automatic chk_w(input logic [11:0] a, input int up,
      input logic [31:0] d, input int n);
    chk(32'(wa.size()), 32'(n));
    for (int j = 0; j < n && j < wa.size(); j++) begin
      chk(32'(wa[j]), 32'(up ? a + 12'(j) : a - 12'(j)));
      chk(32'(wv[j]), 32'(d[8 * j +: 8]));
    end
    wa.delete();
    wv.delete();
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (i2c_addr_nack !== v && n < 1000) begin
      @(posedge clk_sys);
      n++;
    end
    idle(2);
  endtask
  task automatic do_reset(input logic bs);
    @(posedge clk_sys);
    nrst <= 1'b0;
    boot_sel <= bs;
    u_host.tick();
    idle(20);
    nrst <= 1'b1;
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #400000;
    bad_count++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    boot_sel = 1'b0;
    nvm_fail = 1'b0;
    status_alt = 1'b1;
    for (int i = 0; i < 4096; i++) bank[i] = 8'(i) ^ 8'h5a;
    do_reset(1'b0);
    idle(60);
    chk(outputs_run, 1);
    chk(i2c_addr_nack, 0);
    chk(first_status_output, 1);
    wr(12'h012, 32'h332211, 3);
    chk_w(12'h012, 0, 32'h332211, 3);
    rd(12'h012, 3, q);
    chk(q, 32'h332211);
    wr(12'h001, 32'heeff00d1, 4);
    chk_w(12'h001, 0, 32'h00d1, 2);
    rd(12'h001, 4, q);
    chk(q, 32'h000000d1);
    u_host.frame(16'h1012, 32'h55, 1, q);
    chk_w(12'h012, 0, 32'h0, 0);
    wr(12'h000, 32'h42, 1);
    chk_w(12'h000, 0, 32'h42, 1);
    u_host.lsb = 1'b1;
    wr(12'h100, 32'hbbaa, 2);
    chk_w(12'h100, 1, 32'hbbaa, 2);
    rd(12'h100, 2, q);
    chk(q, 32'hbbaa);
    wr(12'h000, 32'h0, 1);
    u_host.lsb = 1'b0;
    chk_w(12'h000, 0, 32'h0, 1);
    q = 32'(upd);
    wr(12'h234, 32'h01, 1);
    idle(10);
    chk(32'(upd), q + 1);
    wr(12'h232, 32'h10, 1);
    idle(10);
    chk(first_status_output, 0);
    wr(12'hb03, 32'h01, 1);
    idle(20);
    chk(nvm_writing, 0);
    chk(i2c_addr_nack, 0);
    wr(12'h0f3, 32'h02, 1);
    chk_w(12'h0f3, 0, 32'h02, 1);
    wr(12'hb02, 32'h01, 1);
    wr(12'hb03, 32'h01, 1);
    wait_busy(1);
    chk(i2c_addr_nack, 1);
    chk(first_status_output, 1);
    chk(nvm_writing, 1);
    rd(12'hb00, 1, q);
    chk(q[0], 1);
    wr(12'h020, 32'h77, 1);
    rd(12'h012, 1, q);
    chk(q, 0);
    chk_w(12'h020, 0, 32'h0, 0);
    wait_busy(0);
    chk(i2c_addr_nack, 0);
    chk(nvm_writing, 0);
    rd(12'hb01, 1, q);
    chk(q[0], 0);
    @(posedge clk_sys);
    nvm_fail <= 1'b1;
    wr(12'hb02, 32'h02, 1);
    wait_busy(1);
    chk(i2c_addr_nack, 1);
    wait_busy(0);
    nvm_fail <= 1'b0;
    rd(12'hb01, 1, q);
    chk(q[0], 1);
    wr(12'hb03, 32'h01, 1);
    idle(20);
    chk(i2c_addr_nack, 0);
    do_reset(1'b1);
    idle(10);
    chk(i2c_addr_nack, 1);
    chk(outputs_run, 0);
    wait_busy(0);
    idle(5);
    chk(outputs_run, 1);
    rd(12'h101, 2, q);
    chk(q, 32'haabb);
    wrap_up();
  end
endmodule
`default_nettype wire
